//--- hw/sms_defines.vh
// constants for the serial master service scheduler
`ifndef SMS_DEFINES_VH
`define SMS_DEFINES_VH

// ----------------------------------------
// table size and field widths
// ----------------------------------------
`define SMS_MAX_SERVICES      50
`define SMS_IDX_W             6
`define SMS_ADDR_W            12
`define SMS_BUF_DEPTH         4096

// ----------------------------------------
// service types
// ----------------------------------------
`define SMS_SVC_INTEGRITY     2'h0
`define SMS_SVC_DIAG          2'h1
`define SMS_SVC_READ          2'h2
`define SMS_SVC_WRITE         2'h3

// ----------------------------------------
// node types
// ----------------------------------------
`define SMS_NODE_A            2'h0
`define SMS_NODE_B            2'h1
`define SMS_NODE_C            2'h2

// ----------------------------------------
// serial commands chosen per service and node type
// ----------------------------------------
`define SMS_CMD_ECHO          3'h0
`define SMS_CMD_DIAG          3'h1
`define SMS_CMD_RD_TYPED      3'h2
`define SMS_CMD_WR_TYPED      3'h3
`define SMS_CMD_RD_PROT       3'h4
`define SMS_CMD_WR_PROT       3'h5

// ----------------------------------------
// offline policies
// ----------------------------------------
`define SMS_FB_CLEAR          2'h0
`define SMS_FB_FREEZE         2'h1
`define SMS_FB_NOSCAN         2'h2
`define SMS_SN_CLEAR          1'b0
`define SMS_SN_FREEZE         1'b1

// ----------------------------------------
// update modes
// ----------------------------------------
`define SMS_UPD_CYCLIC        2'h0
`define SMS_UPD_CHANGE        2'h1
`define SMS_UPD_SINGLE        2'h2
`define SMS_UPD_TRIGGER       2'h3

// ----------------------------------------
// byte swap modes
// ----------------------------------------
`define SMS_SWAP_NONE         2'h0
`define SMS_SWAP_WORD         2'h1
`define SMS_SWAP_DWORD        2'h2

// ----------------------------------------
// defaults and limits
// ----------------------------------------
`define SMS_DEF_RETRIES       4'h3
`define SMS_DEF_TIMEOUT       16'h0064
`define SMS_DEF_UPDATE        16'h0064
`define SMS_DEF_TRIG_ADDR     12'h5FF
`define SMS_RESP_LO1          12'h200
`define SMS_RESP_HI1          12'h3FF
`define SMS_RESP_LO2          12'h400
`define SMS_RESP_HI2          12'hFFF
`define SMS_DIAG_MAX_AC       8'h1A
`define SMS_DIAG_MAX_B        8'h1C
`define SMS_SIZE_INT          8'h02
`define SMS_SIZE_FLOAT        8'h04

// ----------------------------------------
// timing
// ----------------------------------------
`define SMS_CLK_HZ            50000000
`define SMS_TICK_MS           10
`define SMS_TICK_CYCLES       ((`SMS_CLK_HZ / 1000) * `SMS_TICK_MS)

`endif

//--- hw/sms_scheduler.v
// service scheduler for a half-duplex serial sub-network master
// Operation
// - at most fifty services configured; writes beyond are rejected
// - every service is integrity check, diagnostics read, data read or write
// - serial command chosen from service type and node type
// - policies, mode, timing and triggers kept per service
// - fieldbus offline: clear, freeze or stop scanning outgoing data
// - sub-network offline: clear or freeze data reported to fieldbus
// - update mode: cyclic, on data change, single shot, on trigger
// - resend up to retry count, default three, then mark node disconnected
// - wait timeout in 10 ms ticks before resend, default 100 ticks
// - issues of one service spaced by update time ticks, default 100
// - trigger mode watches request trigger byte, default 0x05FF
// - response trigger byte updated on completion when enabled
// - response trigger address accepted only in 0x200-0x3FF, 0x400-0xFFF
// - integrity check passes when the node answers with rxDone and rxOk; no echo is compared
// - read sizes even bytes; integer 2 bytes, float 4 bytes per element
// - diagnostics size 1-26 or 1-28 bytes by node type
// - byte order: none, swap in words, swap in double words
// - only data length bytes, at most size, written to buffer
// - per-service byte offset places data in the buffer
`timescale 1ns/100ps
`include "sms_defines.vh"

module sms_scheduler (
   input  wire        clock,
   input  wire        rst_b,
   input  wire        cfgWe,
   input  wire [5:0]  cfgIdx,
   input  wire [1:0]  cfgSvcType,
   input  wire [7:0]  cfgNode,
   input  wire [1:0]  cfgNodeType,
   input  wire [1:0]  cfgFbOffline,
   input  wire        cfgSnOffline,
   input  wire [1:0]  cfgUpdMode,
   input  wire [3:0]  cfgRetries,
   input  wire [15:0] cfgTimeout,
   input  wire [15:0] cfgUpdTime,
   input  wire [11:0] cfgReqTrig,
   input  wire        cfgRespEn,
   input  wire [11:0] cfgRespTrig,
   input  wire [1:0]  cfgSwap,
   input  wire        cfgFloat,
   input  wire [7:0]  cfgSize,
   input  wire [7:0]  cfgDataLen,
   input  wire [11:0] cfgOffset,
   output reg         cfgReject,
   input  wire        fbOnline,
   input  wire        snOnline,
   input  wire        busWe,
   input  wire [11:0] busAddr,
   input  wire [7:0]  busWdata,
   output reg  [7:0]  busRdata,
   output wire        reqValid,
   input  wire        reqReady,
   output reg  [2:0]  reqCmd,
   output reg  [7:0]  reqNode,
   output reg  [7:0]  reqLen,
   output reg  [5:0]  reqSvc,
   output reg  [7:0]  txByte,
   output wire        txValid,
   input  wire        txReady,
   input  wire        rxValid,
   input  wire [7:0]  rxByte,
   input  wire        rxDone,
   input  wire        rxOk,
   output reg  [63:0] nodeLost,
   output wire        busy
);

   // ----------------------------------------
   // per-service tables and data buffer
   // ----------------------------------------
   reg [49:0] used_reg;
   reg [1:0]  svcType  [0:49];
   reg [7:0]  svcNode  [0:49];
   reg [1:0]  svcNt    [0:49];
   reg [1:0]  svcFb    [0:49];
   reg        svcSn    [0:49];
   reg [1:0]  svcMode  [0:49];
   reg [3:0]  svcRetry [0:49];
   reg [15:0] svcTo    [0:49];
   reg [15:0] svcUpd   [0:49];
   reg [11:0] svcReqT  [0:49];
   reg        svcRspEn [0:49];
   reg [11:0] svcRspT  [0:49];
   reg [1:0]  svcSwap  [0:49];
   reg [7:0]  svcSize  [0:49];
   reg [7:0]  svcLen   [0:49];
   reg [11:0] svcOff   [0:49];
   reg [15:0] svcWait  [0:49];
   reg [7:0]  svcTrig  [0:49];
   reg [49:0] done_reg;
   reg [49:0] dirty_reg;
   reg [7:0]  mem      [0:4095];

   localparam ST_IDLE = 3'h0;
   localparam ST_SEND = 3'h1;
   localparam ST_TX   = 3'h2;
   localparam ST_RX   = 3'h3;
   localparam ST_WAIT = 3'h4;
   localparam ST_DONE = 3'h5;

   reg [2:0]  state_reg;
   reg [5:0]  cur_reg;
   reg [5:0]  scan_reg;
   reg [3:0]  tries_reg;
   reg [7:0]  cnt_reg;
   reg [15:0] tmo_reg;
   reg [19:0] pre_reg;
   reg        tick_reg;
   reg        snLast_reg;

   // ----------------------------------------
   // configuration checks
   // ----------------------------------------
   wire [7:0] diagMax = (cfgNodeType == `SMS_NODE_B) ? `SMS_DIAG_MAX_B : `SMS_DIAG_MAX_AC;
   wire       cfgOk   = !(
      cfgIdx >= 6'd50 ||
      cfgRespTrig < `SMS_RESP_LO1 ||
      (cfgSvcType == `SMS_SVC_DIAG && (cfgSize == 8'h00 || cfgSize > diagMax)) ||
      (cfgSvcType[1] && (cfgSize == 8'h00 || cfgSize[0] || (cfgFloat && cfgSize[1]))) ||
      cfgDataLen > cfgSize);

   // command per service and node type
   wire       nodeA   = svcNt[cur_reg] == `SMS_NODE_A;
   wire [2:0] cmdSel  = (svcType[cur_reg] == `SMS_SVC_INTEGRITY) ? `SMS_CMD_ECHO :
                        (svcType[cur_reg] == `SMS_SVC_DIAG) ? `SMS_CMD_DIAG :
                        (svcType[cur_reg] == `SMS_SVC_WRITE) ?
                        (nodeA ? `SMS_CMD_WR_TYPED : `SMS_CMD_WR_PROT) :
                        (nodeA ? `SMS_CMD_RD_TYPED : `SMS_CMD_RD_PROT);

   // swapped byte position within the transfer
   function [7:0] swapIdx;
      input [1:0] mode;
      input [7:0] k;
      begin
         case (mode)
            `SMS_SWAP_WORD:  swapIdx = k ^ 8'h01;
            `SMS_SWAP_DWORD: swapIdx = k ^ 8'h03;
            default:         swapIdx = k;
         endcase
      end
   endfunction

   wire [7:0]  sIdx    = swapIdx(svcSwap[cur_reg], cnt_reg);
   wire [11:0] memAddr = svcOff[cur_reg] + {4'h0, sIdx};
   wire        fbOff   = ~fbOnline;
   wire        isWr    = svcType[cur_reg] == `SMS_SVC_WRITE;
   wire [7:0]  trigNow = mem[svcReqT[scan_reg]];
   // next byte is fetched ahead so txByte holds until the partner takes it
   wire [7:0]  txCnt   = (state_reg == ST_TX) ? cnt_reg + 8'h01 : 8'h00;
   wire [11:0] txAddr  = svcOff[cur_reg] + {4'h0, swapIdx(svcSwap[cur_reg], txCnt)};
   // clear policy sends zeros while fieldbus offline
   wire [7:0]  txData  = (fbOff && svcFb[cur_reg] == `SMS_FB_CLEAR) ? 8'h00 : mem[txAddr];
   wire [31:0] tickLd  = `SMS_TICK_CYCLES - 1;

   reg due;
   always @* begin
      due = used_reg[scan_reg] && svcWait[scan_reg] == 16'h0000 && snOnline;
      if (fbOff && svcFb[scan_reg] == `SMS_FB_NOSCAN)
         due = 1'b0;
      case (svcMode[scan_reg])
         `SMS_UPD_CHANGE:  due = due && (dirty_reg[scan_reg] || !done_reg[scan_reg]);
         `SMS_UPD_SINGLE:  due = due && !done_reg[scan_reg];
         `SMS_UPD_TRIGGER: due = due && trigNow != svcTrig[scan_reg];
         default:          due = due;
      endcase
   end

   assign reqValid = state_reg == ST_SEND;
   assign txValid  = state_reg == ST_TX;
   assign busy     = state_reg != ST_IDLE;

   // ----------------------------------------
   // 10 ms tick
   // ----------------------------------------
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pre_reg  <= 20'h00000;
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= pre_reg == 20'h00000;
         if (pre_reg == 20'h00000)
            pre_reg <= tickLd[19:0];
         else
            pre_reg <= pre_reg - 20'h00001;
      end
   end

   // ----------------------------------------
   // sub-network offline: clear reported data
   // ----------------------------------------
   // clear policy zeroes one byte per cycle; frozen data is left alone
   reg  [7:0]  clrCnt_reg;
   reg  [5:0]  clrSvc_reg;
   reg         clrRun_reg;
   wire        clrLast = !used_reg[clrSvc_reg] || clrCnt_reg + 8'h01 >= svcLen[clrSvc_reg];
   wire        clrHit  = clrRun_reg && used_reg[clrSvc_reg] && svcSn[clrSvc_reg] == `SMS_SN_CLEAR
                         && svcType[clrSvc_reg] != `SMS_SVC_WRITE && svcLen[clrSvc_reg] != 8'h00;
   wire [11:0] clrAddr = svcOff[clrSvc_reg] + {4'h0, clrCnt_reg};
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         clrCnt_reg <= 8'h00;
         clrSvc_reg <= 6'h00;
         clrRun_reg <= 1'b0;
      end else if (snLast_reg && !snOnline) begin
         clrRun_reg <= 1'b1;
         clrSvc_reg <= 6'h00;
         clrCnt_reg <= 8'h00;
      end else if (clrRun_reg) begin
         clrCnt_reg <= clrLast ? 8'h00 : clrCnt_reg + 8'h01;
         if (clrLast)
            clrSvc_reg <= clrSvc_reg + 6'h01;
         if (clrLast && clrSvc_reg == 6'd49)
            clrRun_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // buffer port; transfers and fieldbus writes
   // ----------------------------------------
   wire takeRx = state_reg == ST_RX && rxValid && !isWr && cnt_reg < svcLen[cur_reg];
   always @(posedge clock) begin
      if (takeRx)
         mem[memAddr] <= rxByte;
      else if (state_reg == ST_DONE && svcRspEn[cur_reg])
         mem[svcRspT[cur_reg]] <= mem[svcRspT[cur_reg]] + 8'h01;
      else if (clrHit)
         mem[clrAddr] <= 8'h00;
      else if (busWe)
         mem[busAddr] <= busWdata;
      busRdata <= mem[busAddr];
   end

   // ----------------------------------------
   // configuration store, update wait and trigger snapshot
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < 50; g = g + 1) begin : gSvc
         always @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
               svcWait[g] <= 16'h0000;
               svcTrig[g] <= 8'h00;
            end else if (cfgWe && cfgOk && cfgIdx == g) begin
               svcWait[g] <= 16'h0000;
               svcTrig[g] <= 8'h00;
            end else if (state_reg == ST_DONE && cur_reg == g) begin
               svcWait[g] <= svcUpd[g];
               if (svcMode[g] == `SMS_UPD_TRIGGER)
                  svcTrig[g] <= mem[svcReqT[g]];
            end else if (tick_reg && svcWait[g] != 16'h0000) begin
               svcWait[g] <= svcWait[g] - 16'h0001;
            end
         end
      end
   endgenerate

   always @(posedge clock) begin
      if (cfgWe && cfgOk) begin
         svcType[cfgIdx]  <= cfgSvcType;
         svcNode[cfgIdx]  <= cfgNode;
         svcNt[cfgIdx]    <= cfgNodeType;
         svcFb[cfgIdx]    <= cfgFbOffline;
         svcSn[cfgIdx]    <= cfgSnOffline;
         svcMode[cfgIdx]  <= cfgUpdMode;
         svcRetry[cfgIdx] <= cfgRetries;
         svcTo[cfgIdx]    <= cfgTimeout;
         svcUpd[cfgIdx]   <= cfgUpdTime;
         svcReqT[cfgIdx]  <= cfgReqTrig;
         svcRspEn[cfgIdx] <= cfgRespEn;
         svcRspT[cfgIdx]  <= cfgRespTrig;
         svcSwap[cfgIdx]  <= cfgSwap;
         svcSize[cfgIdx]  <= cfgSize;
         svcLen[cfgIdx]   <= cfgDataLen;
         svcOff[cfgIdx]   <= cfgOffset;
      end
   end

   // ----------------------------------------
   // transaction sequencer
   // ----------------------------------------
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_reg  <= ST_IDLE;
         used_reg   <= 50'h0;
         done_reg   <= 50'h0;
         dirty_reg  <= 50'h0;
         cur_reg    <= 6'h00;
         scan_reg   <= 6'h00;
         tries_reg  <= 4'h0;
         cnt_reg    <= 8'h00;
         tmo_reg    <= 16'h0000;
         nodeLost   <= 64'h0;
         cfgReject  <= 1'b0;
         reqCmd     <= 3'h0;
         reqNode    <= 8'h00;
         reqLen     <= 8'h00;
         reqSvc     <= 6'h00;
         txByte     <= 8'h00;
         snLast_reg <= 1'b1;
      end else begin
         cfgReject  <= cfgWe && !cfgOk;
         snLast_reg <= snOnline;
         if (cfgWe && cfgOk) begin
            used_reg[cfgIdx]  <= 1'b1;
            done_reg[cfgIdx]  <= 1'b0;
         end
         case (state_reg)
            ST_IDLE: begin
               if (due) begin
                  cur_reg   <= scan_reg;
                  tries_reg <= 4'h0;
                  state_reg <= ST_SEND;
               end else
                  scan_reg <= (scan_reg == 6'd49) ? 6'h00 : scan_reg + 6'h01;
            end
            ST_SEND: begin
               reqCmd  <= cmdSel;
               reqNode <= svcNode[cur_reg];
               reqLen  <= isWr ? svcLen[cur_reg] : svcSize[cur_reg];
               reqSvc  <= cur_reg;
               cnt_reg <= 8'h00;
               tmo_reg <= svcTo[cur_reg];
               if (reqReady && isWr)
                  txByte <= txData;
               if (reqReady)
                  state_reg <= isWr ? ST_TX : ST_RX;
            end
            ST_TX: begin
               if (txReady) begin
                  txByte  <= txData;
                  cnt_reg <= cnt_reg + 8'h01;
                  if (cnt_reg + 8'h01 >= svcLen[cur_reg])
                     state_reg <= ST_RX;
               end
            end
            ST_RX: begin
               if (takeRx)
                  cnt_reg <= cnt_reg + 8'h01;
               if (tick_reg && tmo_reg != 16'h0000)
                  tmo_reg <= tmo_reg - 16'h0001;
               if (rxDone && rxOk) begin
                  state_reg <= ST_DONE;
                  nodeLost[svcNode[cur_reg][5:0]] <= 1'b0;
               end else if (rxDone || tmo_reg == 16'h0000)
                  state_reg <= ST_WAIT;
            end
            ST_WAIT: begin
               if (tick_reg && tmo_reg != 16'h0000)
                  tmo_reg <= tmo_reg - 16'h0001;
               if (tmo_reg == 16'h0000) begin
                  if (tries_reg >= svcRetry[cur_reg]) begin
                     nodeLost[svcNode[cur_reg][5:0]] <= 1'b1;
                     state_reg <= ST_IDLE;
                  end else begin
                     tries_reg <= tries_reg + 4'h1;
                     state_reg <= ST_SEND;
                  end
               end
            end
            ST_DONE: begin
               done_reg[cur_reg]  <= 1'b1;
               dirty_reg[cur_reg] <= 1'b0;
               state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
         // data change marks services dirty; set wins over the clear in DONE
         if (busWe)
            dirty_reg <= {50{1'b1}};
      end
   end

endmodule

//--- tb/sms_sched_props.sv
// port checks for the service scheduler
`timescale 1ns/100ps
`include "sms_defines.vh"
module sms_sched_props (
   input wire        clock,
   input wire        rst_b,
   input wire        cfgWe,
   input wire [5:0]  cfgIdx,
   input wire [1:0]  cfgSvcType,
   input wire [1:0]  cfgNodeType,
   input wire        cfgRespEn,
   input wire [11:0] cfgRespTrig,
   input wire [7:0]  cfgSize,
   input wire [7:0]  cfgDataLen,
   input wire        cfgReject,
   input wire        reqValid,
   input wire        reqReady,
   input wire [2:0]  reqCmd,
   input wire [7:0]  reqLen,
   input wire [5:0]  reqSvc,
   input wire [7:0]  txByte,
   input wire        txValid,
   input wire        txReady
);
   // --------
   // request steps
   // --------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   wire [7:0] diagMax = (cfgNodeType == `SMS_NODE_B) ? `SMS_DIAG_MAX_B : `SMS_DIAG_MAX_AC;
   sequence handoff;
      reqValid && reqReady;
   endsequence
   // first cycle of a send is skipped: fields load then
   sequence reqWait;
      reqValid && !reqReady && $past(reqValid);
   endsequence
   idx_reject_a: assert property (cfgWe && cfgIdx > 6'h31 |=> cfgReject)
      else $error("index beyond table accepted");
   reject_cause_a: assert property (cfgReject |-> $past(cfgWe))
      else $error("reject without a write");
   resp_range_a: assert property (
      cfgWe && cfgRespEn && cfgRespTrig < `SMS_RESP_LO1 |=> cfgReject)
      else $error("low response address accepted");
   odd_size_a: assert property (cfgWe && cfgSvcType[1] && cfgSize[0] |=> cfgReject)
      else $error("odd read size accepted");
   diag_size_a: assert property (
      cfgWe && cfgSvcType == `SMS_SVC_DIAG && cfgSize > diagMax |=> cfgReject)
      else $error("diagnostics size over limit accepted");
   data_len_a: assert property (
      cfgWe && cfgSvcType != `SMS_SVC_INTEGRITY && cfgDataLen > cfgSize |=> cfgReject)
      else $error("data length over size accepted");
   req_hold_a: assert property (reqWait |=> reqValid && $stable(reqCmd)
      && $stable(reqLen) && $stable(reqSvc))
      else $error("request dropped or changed while waiting");
   one_txn_a: assert property (handoff |=> !reqValid [*2])
      else $error("new request right after handoff");
   tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txByte))
      else $error("transmit byte changed before taken");
endmodule

bind sms_scheduler sms_sched_props chk (.*);

//--- tb/sms_slave_model.sv
// slave node model answering scheduler requests
`timescale 1ns/100ps
`include "sms_defines.vh"
module sms_slave_model (
   input  wire       clock,
   input  wire       reqValid,
   output reg        reqReady,
   input  wire [2:0] reqCmd,
   input  wire [7:0] reqLen,
   input  wire [7:0] txByte,
   input  wire       txValid,
   output reg        txReady,
   output reg        rxValid,
   output reg  [7:0] rxByte,
   output reg        rxDone,
   output reg        rxOk,
   input  wire [1:0] slow,
   input  wire [7:0] base,
   output reg  [2:0] lastCmd,
   output integer    served
);
   reg [7:0] wrBuf [0:63];
   integer   n;
   integer   i;
   // --------
   // answer loop
   // --------
   initial begin
      reqReady = 1'b0;
      txReady = 1'b0;
      rxValid = 1'b0;
      rxByte = 8'h00;
      rxDone = 1'b0;
      rxOk = 1'b0;
      lastCmd = 3'h0;
      served = 0;
      forever begin
         @(posedge clock);
         if (reqValid === 1'b1) begin
            repeat (slow) @(posedge clock);
            #1 reqReady = 1'b1;
            @(posedge clock);
            lastCmd = reqCmd;
            n = reqLen;
            #1 reqReady = 1'b0;
            if (lastCmd == `SMS_CMD_WR_TYPED || lastCmd == `SMS_CMD_WR_PROT) begin
               for (i = 0; i < n; i = i + 1) begin
                  repeat (slow) @(posedge clock);
                  #1 txReady = 1'b1;
                  @(posedge clock);
                  while (txValid !== 1'b1) @(posedge clock);
                  wrBuf[i] = txByte;
                  #1 txReady = 1'b0;
               end
            end else if (lastCmd != `SMS_CMD_ECHO) begin
               for (i = 0; i < n; i = i + 1) begin
                  @(posedge clock);
                  #1 rxValid = 1'b1;
                  rxByte = base + i[7:0];
               end
            end
            @(posedge clock);
            #1 rxValid = 1'b0;
            // released line shows the inverse, not the last byte
            rxByte = ~rxByte;
            rxDone = 1'b1;
            rxOk = 1'b1;
            @(posedge clock);
            #1 rxDone = 1'b0;
            rxOk = 1'b0;
            served = served + 1;
         end
      end
   end
endmodule

//--- tb/tb_top.sv
// self-checking bench for the service scheduler
`timescale 1ns/100ps
`include "sms_defines.vh"
module tb_top;
   typedef struct packed {
      logic [5:0]  idx;
      logic [1:0]  typ;
      logic [1:0]  nt;
      logic [7:0]  sz;
      logic [7:0]  ln;
      logic        ren;
      logic [11:0] rtr;
      logic        rej;
   } sms_row_t;
   sms_row_t    rows [0:8];
   logic        clock, rst_b, cfgWe, cfgRespEn, cfgSnOffline, cfgFloat, fbOnline, snOnline;
   logic        busWe, cfgReject, reqValid, reqReady, txValid, txReady, rxValid, rxDone;
   logic        rxOk, busy;
   logic [1:0]  cfgSvcType, cfgNodeType, cfgFbOffline, cfgUpdMode, cfgSwap, slow;
   logic [2:0]  reqCmd, lastCmd;
   logic [3:0]  cfgRetries;
   logic [5:0]  cfgIdx, reqSvc;
   logic [7:0]  cfgNode, cfgSize, cfgDataLen, busWdata, busRdata, reqNode, reqLen;
   logic [7:0]  txByte, rxByte, base, m;
   logic [11:0] cfgReqTrig, cfgRespTrig, cfgOffset, busAddr;
   logic [15:0] cfgTimeout, cfgUpdTime;
   logic [63:0] nodeLost;
   integer      served, num_errors, samples_checked, cycles, r, j, k, s0;

   sms_scheduler dut (.*);
   sms_slave_model slave (.*);

   // --------
   // helpers
   // --------
   task automatic complete_run;
      if (num_errors == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock);
      #1 busWe = 1'b1;
      busAddr = a;
      busWdata = d;
      @(posedge clock);
      #1 busWe = 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge clock);
      #1 busAddr = a;
      @(posedge clock);
      #1 chk8(busRdata, exp);
   endtask
   task automatic cfg(input logic [5:0] idx, input logic [1:0] typ, input logic [7:0] sz,
                      input logic [7:0] ln, input logic [1:0] sw, input logic [11:0] off);
      @(posedge clock);
      #1 cfgWe = 1'b1;
      cfgIdx = idx;
      cfgSvcType = typ;
      cfgNode = {2'h0, idx};
      cfgSize = sz;
      cfgDataLen = ln;
      cfgSwap = sw;
      cfgOffset = off;
      @(posedge clock);
      #1 cfgWe = 1'b0;
   endtask
   // waits are bounded; a missed answer shows up in the compares
   task automatic run(input logic [5:0] idx, input logic [1:0] typ, input logic [1:0] sw,
                      input logic [11:0] off);
      s0 = served;
      cfg(idx, typ, 8'h08, 8'h06, sw, off);
      for (k = 0; k < 3000 && served == s0; k++) @(posedge clock);
      for (k = 0; k < 50 && busy !== 1'b0; k++) @(posedge clock);
   endtask

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 80000) begin
         num_errors++;
         complete_run;
      end
   end

   initial begin
      {rst_b, cfgWe, cfgRespEn, cfgSnOffline, cfgFloat, busWe, cfgIdx} = 0;
      {cfgSvcType, cfgNodeType, cfgFbOffline, cfgSwap, slow, cfgNode} = 0;
      {cfgSize, cfgDataLen, busWdata, busAddr, cfgOffset, base} = 0;
      {fbOnline, snOnline} = 2'h3;
      cfgUpdMode = `SMS_UPD_SINGLE;
      cfgRetries = `SMS_DEF_RETRIES;
      cfgTimeout = `SMS_DEF_TIMEOUT;
      cfgUpdTime = 16'hFFFF;
      cfgReqTrig = `SMS_DEF_TRIG_ADDR;
      cfgRespTrig = `SMS_DEF_TRIG_ADDR;
      {num_errors, samples_checked, cycles} = 0;
      rows[0] = {6'h32, `SMS_SVC_INTEGRITY, `SMS_NODE_A, 8'h02, 8'h02, 13'h05FF, 1'b1};
      rows[1] = {6'h31, `SMS_SVC_INTEGRITY, `SMS_NODE_A, 8'h02, 8'h02, 13'h05FF, 1'b0};
      rows[2] = {6'h30, `SMS_SVC_READ, `SMS_NODE_A, 8'h07, 8'h02, 13'h05FF, 1'b1};
      rows[3] = {6'h2F, `SMS_SVC_READ, `SMS_NODE_A, 8'h04, 8'h06, 13'h05FF, 1'b1};
      rows[4] = {6'h2E, `SMS_SVC_DIAG, `SMS_NODE_B, 8'h1E, 8'h02, 13'h05FF, 1'b1};
      rows[5] = {6'h2D, `SMS_SVC_DIAG, `SMS_NODE_B, 8'h1C, 8'h02, 13'h05FF, 1'b0};
      rows[6] = {6'h2C, `SMS_SVC_DIAG, `SMS_NODE_A, 8'h1C, 8'h02, 13'h05FF, 1'b1};
      rows[7] = {6'h2B, `SMS_SVC_READ, `SMS_NODE_A, 8'h04, 8'h04, 13'h11FF, 1'b1};
      rows[8] = {6'h2A, `SMS_SVC_READ, `SMS_NODE_A, 8'h04, 8'h04, 13'h1200, 1'b0};
      repeat (2) @(posedge clock);
      #1 rst_b = 1'b1;
      chk8({busy, cfgReject, nodeLost[5:0]}, 8'h00);
      // --------
      // configuration table
      // --------
      for (r = 0; r < 9; r++) begin
         cfgNodeType = rows[r].nt;
         cfgRespEn = rows[r].ren;
         cfgRespTrig = rows[r].rtr;
         cfg(rows[r].idx, rows[r].typ, rows[r].sz, rows[r].ln, `SMS_SWAP_NONE, 12'h800);
         chk8({7'h00, cfgReject}, {7'h00, rows[r].rej});
      end
      {cfgRespEn, cfgNodeType} = 3'h0;
      repeat (1500) @(posedge clock);
      // integrity check
      run(6'h00, `SMS_SVC_INTEGRITY, `SMS_SWAP_NONE, 12'h800);
      chk8(served - s0, 8'h01);
      chk8({5'h00, lastCmd}, {5'h00, `SMS_CMD_ECHO});
      // swap modes, short data length, offsets
      for (r = 0; r < 3; r++) begin
         m = (r == 0) ? 8'h00 : (r == 1) ? 8'h01 : 8'h03;
         for (j = 0; j < 8; j++) wr(12'h100 + r * 16 + j, 8'hEE);
         base = 8'h40 + r * 16;
         slow = r;
         run(6'h01 + r, (r == 0) ? `SMS_SVC_DIAG : `SMS_SVC_READ, r, 12'h100 + r * 16);
         chk8(lastCmd, (r == 0) ? `SMS_CMD_DIAG : `SMS_CMD_RD_TYPED);
         for (j = 0; j < 8; j++)
            rd(12'h100 + r * 16 + j, ((j ^ m) < 6) ? base + (j ^ m) : 8'hEE);
      end
      // fieldbus offline policies on write data
      for (j = 0; j < 10; j++) wr(12'h200 + j, (j < 4) ? 8'hA0 + j : 8'h00);
      fbOnline = 1'b0;
      for (r = 0; r < 3; r++) begin
         cfgFbOffline = r;
         run(6'h04 + r, `SMS_SVC_WRITE, `SMS_SWAP_NONE, 12'h200);
         if (r < 2)
            for (j = 0; j < 6; j++)
               chk8(slave.wrBuf[j], (r == 0 || j > 3) ? 8'h00 : 8'hA0 + j);
         else
            chk8(served - s0, 8'h00);
      end
      fbOnline = 1'b1;
      cfgFbOffline = `SMS_FB_CLEAR;
      // update modes: trigger, change, cyclic
      cfgUpdTime = 16'h0000;
      for (r = 0; r < 3; r++) begin
         cfgUpdMode = (r == 0) ? `SMS_UPD_TRIGGER : (r == 1) ? `SMS_UPD_CHANGE : `SMS_UPD_CYCLIC;
         cfgReqTrig = 12'h300;
         if (r == 2) cfgUpdTime = 16'hFFFF;
         cfg(6'h0A + r, `SMS_SVC_INTEGRITY, 8'h02, 8'h02, `SMS_SWAP_NONE, 12'h800);
         repeat (1500) @(posedge clock);
         s0 = served;
         if (r < 2) wr(12'h300 + r, 8'h5A);
         repeat (1500) @(posedge clock);
         chk8(served - s0, (r < 2) ? 8'h01 : 8'h00);
      end
      // sub-network offline clears read data
      #1 snOnline = 1'b0;
      repeat (400) @(posedge clock);
      rd(12'h100, 8'h00);
      complete_run;
   end
endmodule
